// file: rcwa_bcd_ctr.v
// Two-digit BCD counter with load, bounded range and wrap carry
`timescale 1ns/10ps
`default_nettype none
module rcwa_bcd_ctr #(
   parameter [7:0] RST_VAL = 8'h00
) (
   input wire clk_sys_in,
   input wire nrst_in,
   input wire inc_in,
   input wire load_in,
   input wire [7:0] load_val_in,
   input wire [7:0] lo_in,
   input wire [7:0] hi_in,
   output wire [7:0] val_out,
   output wire wrap_out
);
   reg [7:0] val;
   reg [7:0] next_val;

   assign val_out = val;
   // Carry is combinational so the whole cascade ripples in one tick
   assign wrap_out = inc_in & ~load_in & (val >= hi_in);

   // Decimal increment: ones roll at 9, whole field rolls at the limit
   always @* begin
      if (val >= hi_in) begin
         next_val = lo_in;
      end else if (val[3:0] == 4'h9) begin
         next_val = {val[7:4] + 4'h1, 4'h0};
      end else begin
         next_val = {val[7:4], val[3:0] + 4'h1};
      end
   end

   // Software load wins over a tick in the same cycle
   always @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         val <= RST_VAL;
      end else if (load_in) begin
         val <= load_val_in;
      end else if (inc_in) begin
         val <= next_val;
      end
   end
endmodule
`default_nettype wire

// file: rcwa_checker.sv
// Checker for the calendar clock register windows and output pin
`timescale 1ns/10ps
`default_nettype none
module rcwa_checker (
   input wire clk_sys_in,
   input wire nrst_in,
   input wire xtal_clk_in,
   input wire [2:0] addr_in,
   input wire [15:0] wr_data_in,
   input wire [1:0] wr_be_in,
   input wire wr_in,
   input wire rd_in,
   input wire [15:0] rd_data_out,
   input wire rtc_pin_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!nrst_in);
   logic [1:0] tp, ap;
   logic unl, en, oe, k55, aa1, aa2;
   wire kw = wr_in && addr_in == 3'h4 && wr_be_in[0];
   wire hw = wr_in && wr_be_in[1];
   wire rdc = rd_in && addr_in == 3'h0;
   // Shadow state; the key window is two cycles wide
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         {tp, ap, unl, en, oe, k55, aa1, aa2} <= 10'h000;
      end else begin
         if (kw) k55 <= wr_data_in[7:0] == 8'h55;
         aa1 <= kw && k55 && wr_data_in[7:0] == 8'hAA;
         aa2 <= aa1;
         if (hw && addr_in == 3'h0) begin
            if (unl) en <= wr_data_in[15];
            unl <= wr_data_in[13] && (unl || aa1 || aa2);
            oe <= wr_data_in[10];
            tp <= wr_data_in[9:8];
         end else if ((hw || rd_in) && addr_in == 3'h2 && tp != 2'h0) tp <= tp - 2'h1;
         if (hw && addr_in == 3'h1) ap <= wr_data_in[9:8];
         else if ((hw || rd_in) && addr_in == 3'h3 && ap != 2'h0) ap <= ap - 2'h1;
      end
   end
   a_rd_idle: assert property (!$past(rd_in) |-> rd_data_out == 16'h0000)
      else $error("stray read data");
   a_cfg_ptr: assert property (rdc |=> rd_data_out[9:8] == $past(tp))
      else $error("timer pointer wrong");
   a_cfg_lock: assert property (rdc |=> rd_data_out[13] == $past(unl))
      else $error("write unlock wrong");
   a_cfg_enable: assert property (rdc |=> rd_data_out[15:14] == {$past(en), 1'b0})
      else $error("enable bit wrong");
   a_alcfg_ptr: assert property (
      rd_in && addr_in == 3'h1 |=> rd_data_out[9:8] == $past(ap))
      else $error("alarm pointer wrong");
   a_alarm_gap: assert property (
      rd_in && addr_in == 3'h3 && ap == 2'h3 |=> rd_data_out == 16'h0000)
      else $error("alarm slot 3 not zero");
   a_year_high: assert property (
      rd_in && addr_in == 3'h2 && tp == 2'h3 |=> rd_data_out[15:8] == 8'h00)
      else $error("year high byte not zero");
   a_pin_off: assert property (!oe && !$past(oe) && !$past(oe, 2) |-> !rtc_pin_out)
      else $error("pin on while disabled");
endmodule
bind rcwa_top rcwa_checker u_chk (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
   .xtal_clk_in(xtal_clk_in), .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_be_in(wr_be_in),
   .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out), .rtc_pin_out(rtc_pin_out));
`default_nettype wire

// file: rcwa_consts.vh
// Constants for the calendar clock with pointer-indexed value windows
`ifndef RCWA_CONSTS_VH
`define RCWA_CONSTS_VH
// Register word addresses on the plain register port
`define RCWA_ADDR_CFG 3'h0
`define RCWA_ADDR_ALCFG 3'h1
`define RCWA_ADDR_VAL 3'h2
`define RCWA_ADDR_ALVAL 3'h3
`define RCWA_ADDR_KEY 3'h4
`define RCWA_ADDR_PAD 3'h5
// Timekeeper configuration fields
`define RCWA_CFG_EN 15
`define RCWA_CFG_UNLOCK 13
`define RCWA_CFG_SYNC 12
`define RCWA_CFG_HALF 11
`define RCWA_CFG_OE 10
`define RCWA_CFG_PTR_HI 9
`define RCWA_CFG_PTR_LO 8
// Alarm configuration fields
`define RCWA_AL_EN 15
`define RCWA_AL_CHIME 14
`define RCWA_AL_MASK_HI 13
`define RCWA_AL_MASK_LO 10
// Pad configuration field: seconds clock select
`define RCWA_PAD_SECSEL 1
// Pointer codes
`define RCWA_PTR_MINSEC 2'h0
`define RCWA_PTR_WDHR 2'h1
`define RCWA_PTR_MTHDAY 2'h2
`define RCWA_PTR_YEAR 2'h3
// Unlock key values and window length in clock cycles
`define RCWA_KEY_FIRST 8'h55
`define RCWA_KEY_SECOND 8'hAA
`define RCWA_KEY_WINDOW 2'h2
// Timebase: 32768 pulses of the crystal form one second
`define RCWA_PRESCALE_TOP 15'h7FFF
`define RCWA_SYNC_LEAD 15'h0020
// Reset values of the calendar fields
`define RCWA_RST_SEC 8'h00
`define RCWA_RST_MIN 8'h00
`define RCWA_RST_HOUR 8'h00
`define RCWA_RST_WDAY 8'h00
`define RCWA_RST_DAY 8'h01
`define RCWA_RST_MONTH 8'h01
`define RCWA_RST_YEAR 8'h00
// Field limits in BCD
`define RCWA_MAX_SEC 8'h59
`define RCWA_MAX_HOUR 8'h23
`define RCWA_MAX_WDAY 8'h06
`define RCWA_MAX_MONTH 8'h12
`define RCWA_MAX_YEAR 8'h99
`define RCWA_MIN_ZERO 8'h00
`define RCWA_MIN_ONE 8'h01
`endif

// file: rcwa_top.v
// Calendar clock with unlock-guarded timer window and alarm window
// Summary of operation
// RQ1: Keep 24-hour time and weekday, date, month, year, all in BCD.
// RQ2: Year runs 00 to 99, i.e. 2000 through 2099, then wraps.
// RQ3: February gets day 29 automatically in every fourth year.
// RQ4: One-second steps; the half of the current second is readable.
// RQ5: System supplies a 32.768 kHz crystal clock as timebase.
// RQ6: Output pin carries alarm pulse or seconds clock by selection.
// RQ7: Calibration adds or removes up to 512 pulses each minute.
// RQ8: Timer window pointer sits at config bits 9:8.
// RQ9: Timer codes: minsec, weekday-hours, month-day, year low only.
// RQ10: High-byte timer window write decrements pointer, holding at 00.
// RQ11: Alarm window pointer sits at alarm config bits 9:8.
// RQ12: Alarm codes: minsec, weekday-hours, month-day; code 11 unmapped.
// RQ13: High-byte alarm window write decrements pointer, holding at 00.
// RQ14: Any window read decrements its pointer; low-byte writes do not.
// RQ15: Timer value writes are ignored unless write-unlock is set.
// RQ16: Write-unlock may be set only just after keys 55h then AAh.
// RQ17: Software should keep write-unlock clear when not setting time.
// RQ18: Enable bit accepts writes only while write-unlock is set.
// RQ19: Divide crystal by 32768 and cascade BCD carries with month limits.
// RQ20: Crystal clock is synchronised before any logic looks at it.
//
// Implementation choices: strobed register access and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "rcwa_consts.vh"
module rcwa_top (
   input wire clk_sys_in,
   input wire nrst_in,
   input wire xtal_clk_in,
   input wire [2:0] addr_in,
   input wire [15:0] wr_data_in,
   input wire [1:0] wr_be_in,
   input wire wr_in,
   input wire rd_in,
   output reg [15:0] rd_data_out,
   output reg rtc_pin_out
);
   // **********
   // Crystal synchroniser and second divider
   // **********
   localparam KEY_IDLE = 1'b0;
   localparam KEY_GOT_FIRST = 1'b1;

   reg xtal_s1;
   reg xtal_s2;
   reg xtal_s3;
   wire xtal_edge;
   reg [14:0] prescale;
   reg [9:0] cal_skip;
   reg sec_tick;
   reg sec_tick_d;
   reg half_tick;
   reg [7:0] neg_mag;

   // Control registers
   reg tk_enable;
   reg timer_write_unlock;
   reg out_enable;
   reg [1:0] value_window_pointer;
   reg [7:0] cal;
   reg alarm_enable;
   reg chime;
   reg [3:0] alarm_mask;
   reg [1:0] alarm_window_pointer;
   reg [7:0] alarm_repeat;
   reg sec_select;
   reg [7:0] alarm_seconds;
   reg [7:0] alarm_minutes;
   reg [7:0] alarm_hours;
   reg [7:0] alarm_weekday;
   reg [7:0] alarm_day;
   reg [7:0] alarm_month;
   reg key_state;
   reg [1:0] key_win;
   reg alarm_toggle;

   // Decoded bus accesses
   wire wr_cfg = wr_in & (addr_in == `RCWA_ADDR_CFG);
   wire wr_alcfg = wr_in & (addr_in == `RCWA_ADDR_ALCFG);
   wire wr_val = wr_in & (addr_in == `RCWA_ADDR_VAL);
   wire wr_alval = wr_in & (addr_in == `RCWA_ADDR_ALVAL);
   wire wr_key = wr_in & (addr_in == `RCWA_ADDR_KEY) & wr_be_in[0];
   wire wr_pad = wr_in & (addr_in == `RCWA_ADDR_PAD) & wr_be_in[0];
   wire rd_val = rd_in & (addr_in == `RCWA_ADDR_VAL);
   wire rd_alval = rd_in & (addr_in == `RCWA_ADDR_ALVAL);

   // Time field wiring
   wire [7:0] sec;
   wire [7:0] min;
   wire [7:0] hour;
   wire [7:0] wday;
   wire [7:0] day;
   wire [7:0] month;
   wire [7:0] year;
   wire sec_wrap;
   wire min_wrap;
   wire hour_wrap;
   wire day_wrap;
   wire month_wrap;
   wire year_wrap_unused;
   reg [7:0] day_max;
   reg leap;

   // Only the second and third stages feed logic; the crystal is another clock
   always @(posedge clk_sys_in or negedge nrst_in) begin // RQ20
      if (!nrst_in) begin
         xtal_s1 <= 1'b0;
         xtal_s2 <= 1'b0;
         xtal_s3 <= 1'b0;
      end else begin
         xtal_s1 <= xtal_clk_in;
         xtal_s2 <= xtal_s1;
         xtal_s3 <= xtal_s2;
      end
   end
   assign xtal_edge = xtal_s2 & ~xtal_s3; // RQ5

   // Magnitude of a negative calibration value, 1 to 128
   always @* begin
      neg_mag = 8'h00 - cal;
   end

   wire minsec_lo_load = wr_val & wr_be_in[0] & timer_write_unlock &
      (value_window_pointer == `RCWA_PTR_MINSEC);

   // Divider: 32768 crystal pulses per second, trimmed once a minute
   always @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         prescale <= 15'h0000;
         cal_skip <= 10'h000;
         sec_tick <= 1'b0;
         half_tick <= 1'b0;
      end else begin
         sec_tick <= 1'b0;
         half_tick <= 1'b0;
         if (minsec_lo_load) begin
            // Writing seconds restarts the second, so its half reads 0
            prescale <= 15'h0000;
            cal_skip <= 10'h000;
         end else if (tk_enable && xtal_edge) begin
            if (cal_skip != 10'h000) begin
               cal_skip <= cal_skip - 10'h001; // RQ7
            end else if (prescale == `RCWA_PRESCALE_TOP) begin // RQ19
               sec_tick <= 1'b1;
               prescale <= 15'h0000;
               if (sec == `RCWA_MAX_SEC) begin
                  // Minute boundary: apply the drift trim
                  if (cal[7]) begin
                     cal_skip <= {neg_mag, 2'b00}; // RQ7
                  end else begin
                     prescale <= {5'h00, cal, 2'b00}; // RQ7
                  end
               end
            end else begin
               prescale <= prescale + 15'h0001;
               if (prescale == 15'h3FFF) begin
                  half_tick <= 1'b1;
               end
            end
         end
      end
   end

   // **********
   // Calendar cascade
   // **********
   // Leap year within 00..99: every year divisible by four
   always @* begin // RQ3
      leap = (~year[4] & ((year[3:0] == 4'h0) | (year[3:0] == 4'h4) |
         (year[3:0] == 4'h8))) | (year[4] & ((year[3:0] == 4'h2) |
         (year[3:0] == 4'h6)));
      case (month)
         8'h02: begin
            day_max = leap ? 8'h29 : 8'h28;
         end
         8'h04, 8'h06, 8'h09, 8'h11: begin
            day_max = 8'h30;
         end
         default: begin
            day_max = 8'h31;
         end
      endcase
   end

   // Timer window loads, dropped while locked
   wire val_ok = wr_val & timer_write_unlock; // RQ15
   wire ptr0 = (value_window_pointer == `RCWA_PTR_MINSEC); // RQ9
   wire ptr1 = (value_window_pointer == `RCWA_PTR_WDHR);
   wire ptr2 = (value_window_pointer == `RCWA_PTR_MTHDAY);
   wire ptr3 = (value_window_pointer == `RCWA_PTR_YEAR);
   wire ld_sec = val_ok & wr_be_in[0] & ptr0;
   wire ld_min = val_ok & wr_be_in[1] & ptr0;
   wire ld_hour = val_ok & wr_be_in[0] & ptr1;
   wire ld_wday = val_ok & wr_be_in[1] & ptr1;
   wire ld_day = val_ok & wr_be_in[0] & ptr2;
   wire ld_month = val_ok & wr_be_in[1] & ptr2;
   wire ld_year = val_ok & wr_be_in[0] & ptr3;

   // Seconds through years, 24-hour, BCD, years 2000 to 2099
   rcwa_bcd_ctr #(.RST_VAL(`RCWA_RST_SEC)) u_sec ( // RQ1
      .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .inc_in(sec_tick), // RQ4
      .load_in(ld_sec), .load_val_in(wr_data_in[7:0]),
      .lo_in(`RCWA_MIN_ZERO), .hi_in(`RCWA_MAX_SEC),
      .val_out(sec), .wrap_out(sec_wrap));
   rcwa_bcd_ctr #(.RST_VAL(`RCWA_RST_MIN)) u_min (
      .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .inc_in(sec_wrap),
      .load_in(ld_min), .load_val_in(wr_data_in[15:8]),
      .lo_in(`RCWA_MIN_ZERO), .hi_in(`RCWA_MAX_SEC),
      .val_out(min), .wrap_out(min_wrap));
   rcwa_bcd_ctr #(.RST_VAL(`RCWA_RST_HOUR)) u_hour (
      .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .inc_in(min_wrap),
      .load_in(ld_hour), .load_val_in(wr_data_in[7:0]),
      .lo_in(`RCWA_MIN_ZERO), .hi_in(`RCWA_MAX_HOUR),
      .val_out(hour), .wrap_out(hour_wrap));
   rcwa_bcd_ctr #(.RST_VAL(`RCWA_RST_WDAY)) u_wday (
      .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .inc_in(hour_wrap),
      .load_in(ld_wday), .load_val_in(wr_data_in[15:8]),
      .lo_in(`RCWA_MIN_ZERO), .hi_in(`RCWA_MAX_WDAY),
      .val_out(wday), .wrap_out());
   rcwa_bcd_ctr #(.RST_VAL(`RCWA_RST_DAY)) u_day ( // RQ19
      .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .inc_in(hour_wrap),
      .load_in(ld_day), .load_val_in(wr_data_in[7:0]),
      .lo_in(`RCWA_MIN_ONE), .hi_in(day_max),
      .val_out(day), .wrap_out(day_wrap));
   rcwa_bcd_ctr #(.RST_VAL(`RCWA_RST_MONTH)) u_month (
      .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .inc_in(day_wrap),
      .load_in(ld_month), .load_val_in(wr_data_in[15:8]),
      .lo_in(`RCWA_MIN_ONE), .hi_in(`RCWA_MAX_MONTH),
      .val_out(month), .wrap_out(month_wrap));
   rcwa_bcd_ctr #(.RST_VAL(`RCWA_RST_YEAR)) u_year ( // RQ2
      .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .inc_in(month_wrap),
      .load_in(ld_year), .load_val_in(wr_data_in[7:0]),
      .lo_in(`RCWA_MIN_ZERO), .hi_in(`RCWA_MAX_YEAR),
      .val_out(year), .wrap_out(year_wrap_unused));

   // **********
   // Unlock sequence and control registers
   // **********
   // A short key window keeps a stray store from unlocking
   always @(posedge clk_sys_in or negedge nrst_in) begin // RQ16
      if (!nrst_in) begin
         key_state <= KEY_IDLE;
         key_win <= 2'h0;
      end else begin
         if (key_win != 2'h0) begin
            key_win <= key_win - 2'h1;
         end
         if (wr_key) begin
            case (key_state)
               KEY_IDLE: begin
                  if (wr_data_in[7:0] == `RCWA_KEY_FIRST) begin
                     key_state <= KEY_GOT_FIRST;
                  end
               end
               KEY_GOT_FIRST: begin
                  key_state <= (wr_data_in[7:0] == `RCWA_KEY_FIRST) ? KEY_GOT_FIRST : KEY_IDLE;
                  if (wr_data_in[7:0] == `RCWA_KEY_SECOND) begin
                     key_win <= `RCWA_KEY_WINDOW;
                  end
               end
               default: begin
                  key_state <= KEY_IDLE;
               end
            endcase
         end
      end
   end

   // Timekeeper configuration and its window pointer
   always @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         tk_enable <= 1'b0;
         timer_write_unlock <= 1'b0;
         out_enable <= 1'b0;
         value_window_pointer <= 2'h0;
         cal <= 8'h00;
      end else begin
         if (wr_cfg && wr_be_in[1]) begin
            if (timer_write_unlock) begin
               tk_enable <= wr_data_in[`RCWA_CFG_EN]; // RQ18
            end
            // Clearing is always allowed; setting needs the key window
            if (!wr_data_in[`RCWA_CFG_UNLOCK] || key_win != 2'h0) begin
               timer_write_unlock <= wr_data_in[`RCWA_CFG_UNLOCK]; // RQ16
            end
            out_enable <= wr_data_in[`RCWA_CFG_OE];
            value_window_pointer <=
               wr_data_in[`RCWA_CFG_PTR_HI:`RCWA_CFG_PTR_LO]; // RQ8
         end else if ((rd_val || (wr_val && wr_be_in[1])) &&
            value_window_pointer != 2'h0) begin
            value_window_pointer <= value_window_pointer - 2'h1; // RQ10 RQ14
         end
         if (wr_cfg && wr_be_in[0]) begin
            cal <= wr_data_in[7:0]; // RQ7
         end
      end
   end

   // Alarm configuration, alarm fields and alarm pointer
   wire al_ptr0 = (alarm_window_pointer == `RCWA_PTR_MINSEC); // RQ12
   wire al_ptr1 = (alarm_window_pointer == `RCWA_PTR_WDHR);
   wire al_ptr2 = (alarm_window_pointer == `RCWA_PTR_MTHDAY);
   reg alarm_fire;

   always @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         alarm_enable <= 1'b0;
         chime <= 1'b0;
         alarm_mask <= 4'h0;
         alarm_window_pointer <= 2'h0;
         alarm_repeat <= 8'h00;
         alarm_seconds <= 8'h00;
         alarm_minutes <= 8'h00;
         alarm_hours <= 8'h00;
         alarm_weekday <= 8'h00;
         alarm_day <= 8'h00;
         alarm_month <= 8'h00;
         sec_select <= 1'b0;
      end else begin
         if (wr_alcfg && wr_be_in[1]) begin
            alarm_enable <= wr_data_in[`RCWA_AL_EN];
            chime <= wr_data_in[`RCWA_AL_CHIME];
            alarm_mask <= wr_data_in[`RCWA_AL_MASK_HI:`RCWA_AL_MASK_LO];
            alarm_window_pointer <=
               wr_data_in[`RCWA_CFG_PTR_HI:`RCWA_CFG_PTR_LO]; // RQ11
         end else begin
            if ((rd_alval || (wr_alval && wr_be_in[1])) &&
               alarm_window_pointer != 2'h0) begin
               alarm_window_pointer <= alarm_window_pointer - 2'h1; // RQ13 RQ14
            end
            // Last event of a non-chiming alarm switches it off
            if (alarm_fire && alarm_repeat == 8'h00 && !chime) begin
               alarm_enable <= 1'b0;
            end
         end
         if (wr_alcfg && wr_be_in[0]) begin
            alarm_repeat <= wr_data_in[7:0];
         end else if (alarm_fire && (alarm_repeat != 8'h00 || chime)) begin
            alarm_repeat <= alarm_repeat - 8'h01;
         end
         if (wr_alval && wr_be_in[0]) begin
            if (al_ptr0) alarm_seconds <= wr_data_in[7:0];
            if (al_ptr1) alarm_hours <= wr_data_in[7:0];
            if (al_ptr2) alarm_day <= wr_data_in[7:0];
         end
         if (wr_alval && wr_be_in[1]) begin
            if (al_ptr0) alarm_minutes <= wr_data_in[15:8];
            if (al_ptr1) alarm_weekday <= wr_data_in[15:8];
            if (al_ptr2) alarm_month <= wr_data_in[15:8];
         end
         if (wr_pad) begin
            sec_select <= wr_data_in[`RCWA_PAD_SECSEL];
         end
      end
   end

   // **********
   // Alarm compare and output pin
   // **********
   // Compare one cycle after the tick, once the cascade has settled
   wire m_sec = (sec == alarm_seconds);
   wire m_min = m_sec & (min == alarm_minutes);
   wire m_hour = m_min & (hour == alarm_hours);
   always @* begin
      case (alarm_mask)
         4'h0: alarm_fire = half_tick | sec_tick_d;
         4'h1: alarm_fire = sec_tick_d;
         4'h2: alarm_fire = sec_tick_d & (sec[3:0] == alarm_seconds[3:0]);
         4'h3: alarm_fire = sec_tick_d & m_sec;
         4'h4: alarm_fire = sec_tick_d & m_sec & (min[3:0] == alarm_minutes[3:0]);
         4'h5: alarm_fire = sec_tick_d & m_min;
         4'h6: alarm_fire = sec_tick_d & m_hour;
         4'h7: alarm_fire = sec_tick_d & m_hour & (wday == alarm_weekday);
         4'h8: alarm_fire = sec_tick_d & m_hour & (day == alarm_day);
         4'h9: alarm_fire = sec_tick_d & m_hour & (day == alarm_day) &
            (month == alarm_month);
         default: alarm_fire = 1'b0;
      endcase
      alarm_fire = alarm_fire & alarm_enable;
   end

   // Pin shows one-second square wave or an alarm toggle
   always @(posedge clk_sys_in or negedge nrst_in) begin // RQ6
      if (!nrst_in) begin
         sec_tick_d <= 1'b0;
         alarm_toggle <= 1'b0;
         rtc_pin_out <= 1'b0;
      end else begin
         sec_tick_d <= sec_tick;
         if (alarm_fire) begin
            alarm_toggle <= ~alarm_toggle;
         end
         rtc_pin_out <= out_enable & (sec_select ? ~prescale[14] : alarm_toggle);
      end
   end

   // **********
   // Read port
   // **********
   // Data stand only in the cycle after the read strobe
   always @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rd_data_out <= 16'h0000;
      end else if (rd_in) begin
         case (addr_in)
            `RCWA_ADDR_CFG: rd_data_out <= {tk_enable, 1'b0, timer_write_unlock,
               (prescale >= `RCWA_PRESCALE_TOP - `RCWA_SYNC_LEAD), prescale[14], // RQ4
               out_enable, value_window_pointer, cal};
            `RCWA_ADDR_ALCFG: rd_data_out <= {alarm_enable, chime, alarm_mask,
               alarm_window_pointer, alarm_repeat};
            `RCWA_ADDR_VAL: begin // RQ9
               case (value_window_pointer)
                  `RCWA_PTR_MINSEC: rd_data_out <= {min, sec};
                  `RCWA_PTR_WDHR: rd_data_out <= {wday, hour};
                  `RCWA_PTR_MTHDAY: rd_data_out <= {month, day};
                  default: rd_data_out <= {8'h00, year};
               endcase
            end
            `RCWA_ADDR_ALVAL: begin // RQ12
               case (alarm_window_pointer)
                  `RCWA_PTR_MINSEC: rd_data_out <= {alarm_minutes, alarm_seconds};
                  `RCWA_PTR_WDHR: rd_data_out <= {alarm_weekday, alarm_hours};
                  `RCWA_PTR_MTHDAY: rd_data_out <= {alarm_month, alarm_day};
                  default: rd_data_out <= 16'h0000;
               endcase
            end
            `RCWA_ADDR_PAD: rd_data_out <= {14'h0000, sec_select, 1'b0};
            default: rd_data_out <= 16'h0000;
         endcase
      end else begin
         rd_data_out <= 16'h0000;
      end
   end
endmodule
`default_nettype wire

// file: rcwa_xtal.sv
// Crystal partner: free-running 32.768 kHz timebase
`timescale 1ns/10ps
`default_nettype none
module rcwa_xtal #(
   parameter real HALF_NS = 15258.8
) (
   output logic xtal_clk_out
);
   // Free-running, as a crystal is
   initial begin
      xtal_clk_out = 1'b0;
      forever #(HALF_NS) xtal_clk_out = ~xtal_clk_out;
   end
endmodule
`default_nettype wire

// file: rtc_calendar_window_access_tb.sv
// Testbench for the calendar clock with a behavioural register model
`timescale 1ns/10ps
`default_nettype none
module rtc_calendar_window_access_tb;
   logic clk_sys_in = 0, nrst_in = 0, wr_in = 0, rd_in = 0;
   logic [2:0] addr_in = 0;
   logic [15:0] wr_data_in = 0;
   logic [1:0] wr_be_in = 0;
   wire xtal;
   wire [15:0] rd_data_out;
   wire rtc_pin_out;
   int error_cnt = 0, comparisons = 0, seed = 32'h5ad2e881, i;
   logic [15:0] tv [4] = '{16'h0000, 16'h0000, 16'h0101, 16'h0000};
   logic [15:0] av [4] = '{default: 16'h0000};
   logic [1:0] tp = 0, ap = 0;
   logic unl = 0, en = 0, oe = 0, k55 = 0, aa = 0, pad = 0;
   logic [7:0] cal = 0, alo = 0;
   logic [5:0] ahi = 0;
   rcwa_xtal u_xtal (.xtal_clk_out(xtal));
   rcwa_top dut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .xtal_clk_in(xtal),
      .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_be_in(wr_be_in), .wr_in(wr_in),
      .rd_in(rd_in), .rd_data_out(rd_data_out), .rtc_pin_out(rtc_pin_out));
   initial forever #25 clk_sys_in = ~clk_sys_in;
   function automatic logic [7:0] rb(input int lo, n);
      int v;
      v = lo + $unsigned($random(seed)) % n;
      return 8'((v / 10) * 16 + v % 10);
   endfunction
   // Random word for a window slot, legal BCD except a random high byte for the year slot
   function automatic logic [15:0] word(input logic [1:0] p);
      case (p)
         2'h0: return {rb(0, 60), rb(0, 60)};
         2'h1: return {rb(0, 7), rb(0, 24)};
         2'h2: return {rb(1, 12), rb(1, 28)};
         default: return {8'($random(seed)), rb(0, 100)};
      endcase
   endfunction
   task automatic check(input string what, input logic [15:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic report_and_stop;
      $display("Comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // One-cycle write; the model tracks it
   task automatic wr(input logic [2:0] a, input logic [15:0] d, input logic [1:0] be);
      logic nk;
      @(posedge clk_sys_in);
      {wr_in, rd_in, addr_in, wr_data_in, wr_be_in} <= {2'b10, a, d, be};
      nk = a == 3'h4 && be[0] && k55 && d[7:0] == 8'hAA;
      case (a)
         3'h0: begin
            if (be[1]) begin
               if (unl) en = d[15];
               unl = d[13] && (unl || aa);
               {oe, tp} = d[10:8];
            end
            if (be[0]) cal = d[7:0];
         end
         3'h1: begin
            if (be[1]) {ahi, ap} = d[15:8];
            if (be[0]) alo = d[7:0];
         end
         3'h2: begin
            if (unl && be[1] && tp != 3) tv[tp][15:8] = d[15:8];
            if (unl && be[0]) tv[tp][7:0] = d[7:0];
            if (be[1] && tp != 0) tp--;
         end
         3'h3: begin
            if (be[1] && ap != 3) av[ap][15:8] = d[15:8];
            if (be[0] && ap != 3) av[ap][7:0] = d[7:0];
            if (be[1] && ap != 0) ap--;
         end
         3'h4: if (be[0]) k55 = d[7:0] == 8'h55;
         3'h5: if (be[0]) pad = d[1];
         default: ;
      endcase
      aa = nk;
   endtask
   task automatic rd(input logic [2:0] a);
      logic [15:0] e;
      case (a)
         3'h0: e = {en, 1'b0, unl, 2'b00, oe, tp, cal};
         3'h1: e = {ahi, ap, alo};
         3'h2: e = tv[tp];
         3'h3: e = av[ap];
         3'h5: e = {14'h0000, pad, 1'b0};
         default: e = 16'h0000;
      endcase
      if (a == 3'h2 && tp != 0) tp--;
      if (a == 3'h3 && ap != 0) ap--;
      aa = 0;
      @(posedge clk_sys_in);
      {wr_in, rd_in, addr_in} <= {2'b01, a};
      @(posedge clk_sys_in);
      rd_in <= 1'b0;
      #1 check("read", rd_data_out & (a == 0 ? 16'hE7FF : 16'hFFFF), e);
   endtask
   initial begin
      repeat (100000) @(posedge clk_sys_in);
      error_cnt++;
      report_and_stop;
   end
   initial begin
      repeat (10) @(posedge clk_sys_in);
      nrst_in <= 1'b1;
      for (int a = 0; a < 8; a++) rd(a);
      // Refused unlock: no first key, no second key, set too late
      wr(3'h4, 16'h00AA, 2'b01);
      wr(3'h0, 16'h2000, 2'b10);
      wr(3'h4, 16'h0055, 2'b01);
      wr(3'h0, 16'h2000, 2'b10);
      wr(3'h4, 16'h0055, 2'b01);
      wr(3'h4, 16'h00AA, 2'b01);
      rd(3'h0);
      wr(3'h0, 16'h2000, 2'b10);
      wr(3'h2, word(0), 2'b11);
      rd(3'h2);
      // Unlock, then load every timer slot and one more at the bottom
      wr(3'h4, 16'h0055, 2'b01);
      wr(3'h4, 16'h00AA, 2'b01);
      wr(3'h0, {8'h23, 8'($random(seed))}, 2'b11);
      repeat (5) wr(3'h2, word(tp), 2'b11);
      wr(3'h0, {8'h83, cal}, 2'b10);
      rd(3'h0);
      repeat (5) rd(3'h2);
      wr(3'h0, 16'h0000, 2'b10);
      rd(3'h0);
      // Alarm window: gap at code 3, stop at 0, low byte does not step
      wr(3'h1, {6'($random(seed)) & 6'h1F, 2'h3, 8'($random(seed))}, 2'b11);
      repeat (4) wr(3'h3, word(ap), 2'b11);
      rd(3'h1);
      wr(3'h1, {ahi, 2'h2, alo}, 2'b10);
      wr(3'h3, word(2), 2'b01);
      rd(3'h1);
      wr(3'h1, {ahi, 2'h3, alo}, 2'b10);
      repeat (4) rd(3'h3);
      // Seconds clock on the pin after the prescaler restarts
      wr(3'h5, 16'h0002, 2'b01);
      rd(3'h5);
      wr(3'h4, 16'h0055, 2'b01);
      wr(3'h4, 16'h00AA, 2'b01);
      wr(3'h0, {8'hA4, cal}, 2'b10);
      wr(3'h2, {8'h00, rb(0, 60)}, 2'b01);
      @(posedge clk_sys_in) wr_in <= 1'b0;
      for (i = 0; i < 20 && rtc_pin_out !== 1'b1; i++) @(posedge clk_sys_in);
      check("pin", {15'h0000, rtc_pin_out}, 16'h0001);
      rd(3'h0);
      check("half", {15'h0000, rd_data_out[11]}, 16'h0000);
      wr(3'h0, {8'h00, cal}, 2'b10);
      repeat (2) rd(3'h0);
      rd(3'h2);
      report_and_stop;
   end
endmodule
`default_nettype wire
